// *** ddrca_pkg.sv ***
`default_nettype none
package ddrca_pkg;

  // Field widths of the command/address pins
  localparam int ADDR_W = 18;
  localparam int BG_W   = 2;
  localparam int BA_W   = 2;
  localparam int CID_W  = 3;
  localparam int COL_W  = 10;
  localparam int MRS_W  = BG_W + BA_W;

  // Address bit positions with a second meaning, and the upper bank group bit
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int CMD_HI = 16;
  localparam int CMD_LO = 14;
  localparam int BG_HI  = 1;

  // Stack address pin roles in a dual-die package
  localparam int DDP_CKE_BIT = 0;
  localparam int DDP_CS_BIT  = 1;
  localparam int DDP_ODT_BIT = 2;

  // Command code on RAS_n, CAS_n, WE_n when ACT_n is high
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_RFU = 3'h3;
  localparam logic [2:0] CODE_WR  = 3'h4;
  localparam logic [2:0] CODE_RD  = 3'h5;
  localparam logic [2:0] CODE_ZQ  = 3'h6;
  localparam logic [2:0] CODE_NOP = 3'h7;

  // Stacking options, caught as straps
  typedef enum logic [1:0]
  {
    DDRCA_STK_PLAIN = 2'h0,
    DDRCA_STK_DDP   = 2'h1,
    DDRCA_STK_3DS   = 2'h2
  } ddrca_stack_t;

  // Decoded command kind, one-hot
  typedef enum logic [6:0]
  {
    DDRCA_K_NONE = 7'h00,
    DDRCA_K_ACT  = 7'h01,
    DDRCA_K_MRS  = 7'h02,
    DDRCA_K_REF  = 7'h04,
    DDRCA_K_PRE  = 7'h08,
    DDRCA_K_RD   = 7'h10,
    DDRCA_K_WR   = 7'h20,
    DDRCA_K_ZQ   = 7'h40
  } ddrca_kind_t;

  // Pins as sampled from the controller
  typedef struct packed
  {
    logic              act_n;
    logic              cs_n;
    logic              cke;
    logic              odt;
    logic [ADDR_W-1:0] addr;
    logic [BG_W-1:0]   bg;
    logic [BA_W-1:0]   ba;
    logic [CID_W-1:0]  cid;
  } ddrca_pins_t;

  // One decoded command
  typedef struct packed
  {
    logic              valid;
    ddrca_kind_t       kind;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [ADDR_W-1:0] opcode;
    logic [BG_W-1:0]   bg;
    logic [BA_W-1:0]   ba;
    logic [MRS_W-1:0]  mr_sel;
    logic              auto_pre;
    logic              burst_chop;
    logic              pre_all;
  } ddrca_cmd_t;

  // Qualified control levels
  typedef struct packed
  {
    logic cke;
    logic odt;
    logic die1_cs_n;
    logic die1_cke;
    logic die1_odt;
  } ddrca_ctl_t;

  localparam int PIN_W = $bits(ddrca_pins_t);

  // Reset values: deselected, no command
  localparam ddrca_pins_t PINS_RST = '{act_n: 1'b1, cs_n: 1'b1,
                                       default: '0};
  localparam ddrca_cmd_t  CMD_RST  = '{kind: DDRCA_K_NONE, default: '0};
  localparam ddrca_ctl_t  CTL_RST  = '{die1_cs_n: 1'b1, default: '0};

endpackage
`default_nettype wire

// *** ddrca_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrca_pin_sync
#(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Pin side
  input  wire logic [W-1:0] d,
  // Clock side
  output logic      [W-1:0] q
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] q_reg;

  // Three-stage chain; only ff2 reads ff1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
    end
    else if (ce)
    begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // Whole word moves only when two samples agree, keeps fields coherent
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q_reg <= RST_VAL;
    else if (ce && (ff2_reg == ff3_reg))
      q_reg <= ff3_reg; // RULE12
  end

  assign q = q_reg;

  sequence agree_s;
    ce && (ff2_reg == ff3_reg);
  endsequence

  property sample_agree_p;
    @(posedge clk) disable iff (rst)
      agree_s |=> (q_reg == $past(ff3_reg));
  endproperty

  sample_agree_a: assert property (sample_agree_p) // RULE12
    else $error("agreed sample not taken");

  hold_split_a: assert property (@(posedge clk) disable iff (rst)
    (ff2_reg != ff3_reg) |=> $stable(q_reg)) // RULE12
    else $error("output moved on disagreeing samples");

endmodule
`default_nettype wire

// *** ddrca_stack_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrca_stack_sel
  import ddrca_pkg::*;
(
  // Configuration
  input  wire ddrca_pkg::ddrca_stack_t      mode,
  input  wire logic                         x16,
  input  wire logic [ddrca_pkg::CID_W-1:0]  die_id,
  // Sampled pins
  input  wire ddrca_pkg::ddrca_pins_t       pins,
  // Selection and control
  output logic                              sel,
  output ddrca_pkg::ddrca_ctl_t             ctl
);

  logic match;
  logic ddp_on;

  // Chip ID compare in single-load stacks; x16 has no stack pins
  always_comb
  begin
    match  = 1'b1;
    ddp_on = 1'b0;
    case (mode)
      DDRCA_STK_3DS:
        match = x16 || (pins.cid == die_id); // RULE10
      DDRCA_STK_DDP:
        ddp_on = !x16; // RULE11
      default:
        match = 1'b1;
    endcase
  end

  // Shared select, clock enable and termination qualified by the ID
  always_comb
  begin
    sel           = !pins.cs_n && match; // RULE10
    ctl.cke       = pins.cke && match;
    ctl.odt       = pins.odt && match;
    ctl.die1_cs_n = ddp_on ? pins.cid[DDP_CS_BIT] : 1'b1; // RULE11
    ctl.die1_cke  = ddp_on && pins.cid[DDP_CKE_BIT];
    ctl.die1_odt  = ddp_on && pins.cid[DDP_ODT_BIT];
  end

endmodule
`default_nettype wire

// *** ddrca_ca_decode.sv ***
// Summary of operation
// RULE1: Address is row on activate, column on read or write.
// RULE2: Mode register set takes the address as the opcode.
// RULE3: A10 on read or write requests auto precharge when high.
// RULE4: Precharge with A10 low hits one bank, high hits all banks.
// RULE5: A12 on read or write: high full burst, low chopped burst.
// RULE6: ACT_n and CS_n low: activate, shared command pins are row bits.
// RULE7: ACT_n high, CS_n low: RAS_n, CAS_n, WE_n form the command code.
// RULE8: Bank address picks bank, and helps pick the mode register.
// RULE9: Bank group picks group and mode register; x16 ignores BG1.
// RULE10: Stacks of four or eight use stack pins as chip ID qualifiers.
// RULE11: Dual-die package uses stack pins as second die controls.
// RULE12: All inputs are captured on the rising clock edge.
// RULE13: Nothing is decoded while chip select is high.
`timescale 1ns/1ps
`default_nettype none
module ddrca_ca_decode
  import ddrca_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Straps, caught once after reset
  input  wire logic                         x16_strap,
  input  wire ddrca_pkg::ddrca_stack_t      stack_strap,
  input  wire logic [ddrca_pkg::CID_W-1:0]  die_id_strap,
  // Command and address pins
  input  wire ddrca_pkg::ddrca_pins_t       pins_in,
  // Decoded command and control
  output ddrca_pkg::ddrca_cmd_t             cmd,
  output ddrca_pkg::ddrca_ctl_t             ctl
);

  import ddrca_pkg::*;

  logic                 cfg_done_reg;
  logic                 x16_reg;
  ddrca_stack_t         stack_reg;
  logic [CID_W-1:0]     die_id_reg;
  ddrca_pins_t          s;
  logic                 sel;
  ddrca_ctl_t           ctl_c;
  logic                 sel_prev_reg;
  logic                 start;
  logic [2:0]           code;
  logic [BG_W-1:0]      bg_eff;
  ddrca_cmd_t           cmd_next;
  ddrca_cmd_t           cmd_reg;
  ddrca_ctl_t           ctl_reg;

  // Straps are latched on the first enabled edge after release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_done_reg <= 1'b0;
      x16_reg      <= 1'b0;
      stack_reg    <= DDRCA_STK_PLAIN;
      die_id_reg   <= '0;
    end
    else if (ce && !cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      x16_reg      <= x16_strap;
      stack_reg    <= stack_strap;
      die_id_reg   <= die_id_strap;
    end
  end

  // Pins come from another chip, so they pass the synchroniser
  ddrca_pin_sync
  #(
    .W       (PIN_W),
    .RST_VAL (PINS_RST)
  )
  u_sync
  (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (pins_in),
    .q   (s)
  );

  ddrca_stack_sel u_stack
  (
    .mode   (stack_reg),
    .x16    (x16_reg),
    .die_id (die_id_reg),
    .pins   (s),
    .sel    (sel),
    .ctl    (ctl_c)
  );

  // Previous selection; a held command decodes only once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sel_prev_reg <= 1'b0;
    else if (ce)
      sel_prev_reg <= sel && cfg_done_reg;
  end

  assign start  = cfg_done_reg && sel && !sel_prev_reg; // RULE13
  assign code   = s.addr[CMD_HI:CMD_LO]; // RULE7
  // Upper group bit forced low for x16 so it never selects
  assign bg_eff = x16_reg ? {1'b0, s.bg[0]} : s.bg; // RULE9

  // Command decode
  always_comb
  begin
    cmd_next = CMD_RST;
    if (start)
    begin
      if (!s.act_n)
      begin
        cmd_next.valid = 1'b1; // RULE6
        cmd_next.kind  = DDRCA_K_ACT;
        cmd_next.row   = s.addr; // RULE1
        cmd_next.bg    = bg_eff;
        cmd_next.ba    = s.ba; // RULE8
      end
      else
      begin
        case (code) // RULE7
          CODE_MRS:
          begin
            cmd_next.valid  = 1'b1;
            cmd_next.kind   = DDRCA_K_MRS;
            cmd_next.opcode = s.addr; // RULE2
            cmd_next.mr_sel = {bg_eff, s.ba}; // RULE8
          end
          CODE_REF:
          begin
            cmd_next.valid = 1'b1;
            cmd_next.kind  = DDRCA_K_REF;
          end
          CODE_PRE:
          begin
            cmd_next.valid   = 1'b1;
            cmd_next.kind    = DDRCA_K_PRE;
            cmd_next.pre_all = s.addr[AP_BIT]; // RULE4
            cmd_next.bg      = bg_eff;
            cmd_next.ba      = s.ba;
          end
          CODE_RD,
          CODE_WR:
          begin
            cmd_next.valid      = 1'b1;
            cmd_next.kind       = (code == CODE_RD) ? DDRCA_K_RD
                                                    : DDRCA_K_WR;
            cmd_next.col        = s.addr[COL_W-1:0]; // RULE1
            cmd_next.auto_pre   = s.addr[AP_BIT]; // RULE3
            cmd_next.burst_chop = !s.addr[BC_BIT]; // RULE5
            cmd_next.bg         = bg_eff;
            cmd_next.ba         = s.ba; // RULE8
          end
          CODE_ZQ:
          begin
            cmd_next.valid = 1'b1;
            cmd_next.kind  = DDRCA_K_ZQ;
          end
          // Reserved code and no-operation give no command
          default:
            cmd_next = CMD_RST;
        endcase
      end
    end
  end

  // Output registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_reg <= CMD_RST;
    else if (ce)
      cmd_reg <= cmd_next; // RULE12
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctl_reg <= CTL_RST;
    else if (ce)
      ctl_reg <= cfg_done_reg ? ctl_c : CTL_RST; // RULE10
  end

  assign cmd = cmd_reg;
  assign ctl = ctl_reg;

  // Checks

  sequence desel_s;
    cfg_done_reg && ce && !sel;
  endsequence

  sequence act_sel_s;
    ce && sel && !s.act_n;
  endsequence

  property act_decode_p;
    @(posedge clk) disable iff (rst || !ce)
      desel_s ##1 act_sel_s |=> cmd_reg.valid && cmd_reg.kind == DDRCA_K_ACT;
  endproperty

  act_decode_a: assert property (act_decode_p) // RULE6
    else $error("activate not decoded");

  cs_gate_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid |-> $past(!s.cs_n)) // RULE13
    else $error("command decoded with chip select high");

  row_addr_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && cmd_reg.kind == DDRCA_K_ACT
      |-> cmd_reg.row == $past(s.addr)) // RULE1
    else $error("row address wrong");

  col_addr_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && (cmd_reg.kind == DDRCA_K_RD ||
                      cmd_reg.kind == DDRCA_K_WR)
      |-> cmd_reg.col == $past(s.addr[COL_W-1:0])) // RULE1
    else $error("column address wrong");

  mrs_opcode_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && cmd_reg.kind == DDRCA_K_MRS
      |-> cmd_reg.opcode == $past(s.addr)) // RULE2
    else $error("mode register opcode wrong");

  auto_pre_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && (cmd_reg.kind == DDRCA_K_RD ||
                      cmd_reg.kind == DDRCA_K_WR)
      |-> cmd_reg.auto_pre == $past(s.addr[AP_BIT])) // RULE3
    else $error("auto precharge flag wrong");

  pre_all_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && cmd_reg.kind == DDRCA_K_PRE
      |-> cmd_reg.pre_all == $past(s.addr[AP_BIT])) // RULE4
    else $error("precharge scope wrong");

  burst_chop_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && (cmd_reg.kind == DDRCA_K_RD ||
                      cmd_reg.kind == DDRCA_K_WR)
      |-> cmd_reg.burst_chop == !$past(s.addr[BC_BIT])) // RULE5
    else $error("burst chop flag wrong");

  code_path_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && cmd_reg.kind != DDRCA_K_ACT |-> $past(s.act_n)) // RULE7
    else $error("non-activate decoded with ACT_n low");

  bank_sel_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cmd_reg.valid && cmd_reg.kind != DDRCA_K_MRS &&
    cmd_reg.kind != DDRCA_K_REF && cmd_reg.kind != DDRCA_K_ZQ
      |-> cmd_reg.ba == $past(s.ba)) // RULE8
    else $error("bank address wrong");

  x16_group_a: assert property (@(posedge clk) disable iff (rst)
    x16_reg |-> !cmd_reg.bg[BG_HI] && !cmd_reg.mr_sel[MRS_W-1]) // RULE9
    else $error("upper bank group used on x16");

  chip_id_a: assert property (@(posedge clk) disable iff (rst || !ce)
    stack_reg == DDRCA_STK_3DS && !x16_reg && s.cid != die_id_reg
      |=> !cmd_reg.valid && !ctl_reg.cke && !ctl_reg.odt) // RULE10
    else $error("other chip ID was accepted");

  die1_pass_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cfg_done_reg && stack_reg == DDRCA_STK_DDP && !x16_reg
      |=> ctl_reg.die1_cs_n == $past(s.cid[DDP_CS_BIT]) &&
          ctl_reg.die1_cke == $past(s.cid[DDP_CKE_BIT])) // RULE11
    else $error("second die controls wrong");

  // A held selection must never give a second pulse
  sequence sel_held_s;
    ce && sel && sel_prev_reg;
  endsequence

  property once_only_p;
    @(posedge clk) disable iff (rst || !ce)
      sel_held_s |=> !cmd_reg.valid;
  endproperty

  once_only_a: assert property (once_only_p) // RULE13
    else $error("held command decoded twice");

  // Reserved and no-operation codes give no command
  property reserved_code_p;
    @(posedge clk) disable iff (rst || !ce)
      start && s.act_n && (code == CODE_RFU || code == CODE_NOP)
        |=> !cmd_reg.valid;
  endproperty

  reserved_code_a: assert property (reserved_code_p) // RULE7
    else $error("reserved code produced a command");

  // Low select bits follow the bank address pins
  property mr_sel_low_p;
    @(posedge clk) disable iff (rst || !ce)
      cmd_reg.valid && cmd_reg.kind == DDRCA_K_MRS
        |-> cmd_reg.mr_sel[BA_W-1:0] == $past(s.ba);
  endproperty

  mr_sel_low_a: assert property (mr_sel_low_p) // RULE8
    else $error("mode register select wrong");

  // Wide parts keep the second die controls parked
  property x16_stack_p;
    @(posedge clk) disable iff (rst || !ce)
      x16_reg && stack_reg == DDRCA_STK_DDP
        |=> ctl_reg.die1_cs_n && !ctl_reg.die1_cke && !ctl_reg.die1_odt;
  endproperty

  x16_stack_a: assert property (x16_stack_p) // RULE11
    else $error("stack pins used on a wide part");

  // Enable low must hold every output register
  property enable_freeze_p;
    @(posedge clk) disable iff (rst)
      !ce |=> $stable(cmd_reg) && $stable(ctl_reg);
  endproperty

  enable_freeze_a: assert property (enable_freeze_p) // RULE12
    else $error("outputs moved with enable low");

endmodule
`default_nettype wire

// *** ddrca_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrca_ctrl_model
(
  // Clock
  input  wire logic                  clk,
  // Pins toward the decoder
  output var ddrca_pkg::ddrca_pins_t pins
);
  import ddrca_pkg::*;

  // Deselected until the first command
  initial pins = PINS_RST;

  // Hold a command, then deselect; flip the idle lines so stale
  // address values can never pass for a held command
  task automatic issue(input ddrca_pins_t p, input int hold);
    ddrca_pins_t d;
    d = p;
    d.cs_n = 1'b1;
    d.act_n = 1'b1;
    d.addr = ~p.addr;
    d.bg = ~p.bg;
    d.ba = ~p.ba;
    @(negedge clk);
    pins = p;
    repeat (hold) @(negedge clk);
    pins = d;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ddrca_pkg::*;

  logic             clk;
  logic             rst;
  logic             ce;
  logic             x16_strap;
  ddrca_stack_t     stack_strap;
  logic [CID_W-1:0] die_id_strap;
  ddrca_pins_t      pins_in;
  ddrca_cmd_t       cmd;
  ddrca_cmd_t       cap;
  ddrca_ctl_t       ctl;
  int               miscompares;
  int               num_checks;
  int               nval;

  ddrca_ctrl_model ctrl (.clk(clk), .pins(pins_in));

  ddrca_ca_decode dut
  (
    .clk(clk), .rst(rst), .ce(ce), .x16_strap(x16_strap),
    .stack_strap(stack_strap), .die_id_strap(die_id_strap),
    .pins_in(pins_in), .cmd(cmd), .ctl(ctl)
  );

  // Clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Catch each decoded pulse once it has settled
  always @(negedge clk)
  begin
    if (cmd.valid === 1'b1)
    begin
      cap = cmd;
      nval = nval + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Straps are only caught after reset, so each mode needs one
  task automatic do_reset(input logic x, input ddrca_stack_t s,
                          input logic [2:0] id);
    @(negedge clk);
    rst = 1'b1;
    x16_strap = x;
    stack_strap = s;
    die_id_strap = id;
    repeat (2) @(negedge clk);
    check("rst_cmd", 32'(cmd === CMD_RST), 1);
    check("rst_ctl", 32'(ctl === CTL_RST), 1);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  function automatic ddrca_pins_t mk(logic a_n, logic [2:0] code,
    logic [ADDR_W-1:0] a, logic [1:0] g, logic [1:0] b, logic [2:0] c);
    ddrca_pins_t p;
    p = '{act_n: a_n, cs_n: 1'b0, cke: 1'b1, odt: 1'b1, addr: a,
          bg: g, ba: b, cid: c};
    if (a_n)
      p.addr[CMD_HI:CMD_LO] = code;
    return p;
  endfunction

  task automatic send(input ddrca_pins_t p, input int hold);
    nval = 0;
    cap = CMD_RST;
    ctrl.issue(p, hold);
  endtask

  // All codes, a deselected read, a long hold decoding once
  task automatic sc_codes;
    ddrca_kind_t exp_k [8] = '{DDRCA_K_MRS, DDRCA_K_REF, DDRCA_K_PRE,
      DDRCA_K_NONE, DDRCA_K_WR, DDRCA_K_RD, DDRCA_K_ZQ, DDRCA_K_NONE};
    ddrca_pins_t p;
    for (int i = 0; i < 8; i++)
    begin
      send(mk(1'b1, 3'(i), '0, 2'h0, 2'h0, 3'h0), 6);
      check("kind", 32'(cap.kind), 32'(exp_k[i]));
      check("pulses", nval, (exp_k[i] == DDRCA_K_NONE) ? 0 : 1);
    end
    p = mk(1'b1, CODE_RD, '0, 2'h0, 2'h0, 3'h0);
    p.cs_n = 1'b1;
    send(p, 6);
    check("desel", nval, 0);
    send(mk(1'b1, CODE_RD, '0, 2'h0, 2'h0, 3'h0), 20);
    check("held", nval, 1);
  endtask

  // Field meanings per command
  task automatic sc_fields;
    send(mk(1'b1, CODE_RD, 18'h005a5, 2'h2, 2'h1, 3'h0), 6);
    check("rd_kind", 32'(cap.kind), 32'(DDRCA_K_RD));
    check("rd_col", cap.col, 32'h1a5);
    check("rd_ap", cap.auto_pre, 1);
    check("rd_bc", cap.burst_chop, 1);
    check("rd_bank", {cap.bg, cap.ba}, 32'h9);
    send(mk(1'b1, CODE_WR, 18'h01256, 2'h1, 2'h3, 3'h0), 6);
    check("wr_kind", 32'(cap.kind), 32'(DDRCA_K_WR));
    check("wr_col", cap.col, 32'h256);
    check("wr_ap", cap.auto_pre, 0);
    check("wr_bc", cap.burst_chop, 0);
    // Upper row bits would read as a reserved code here
    send(mk(1'b0, 3'h0, 18'h2c3d5, 2'h3, 2'h2, 3'h0), 6);
    check("act_kind", 32'(cap.kind), 32'(DDRCA_K_ACT));
    check("act_row", cap.row, 32'h2c3d5);
    check("act_bank", {cap.bg, cap.ba}, 32'he);
    send(mk(1'b1, CODE_MRS, 18'h20abc, 2'h3, 2'h2, 3'h0), 6);
    check("mrs_op", cap.opcode, 32'h20abc);
    check("mrs_sel", cap.mr_sel, 32'he);
    for (int ap = 0; ap < 2; ap++)
    begin
      send(mk(1'b1, CODE_PRE, 18'(ap) << AP_BIT, 2'h1, 2'h2, 3'h0), 6);
      check("pre_all", cap.pre_all, ap);
      check("pre_bank", {cap.bg, cap.ba}, 32'h6);
    end
  endtask

  // Wide part: upper group bit and stack pins ignored
  task automatic sc_x16;
    do_reset(1'b1, DDRCA_STK_3DS, 3'h5);
    send(mk(1'b1, CODE_MRS, 18'h00001, 2'h3, 2'h1, 3'h7), 6);
    check("x16_sel", cap.mr_sel, 32'h5);
    check("x16_cid", nval, 1);
    send(mk(1'b1, CODE_RD, '0, 2'h3, 2'h1, 3'h7), 6);
    check("x16_bg", cap.bg, 32'h1);
  endtask

  // Chip ID qualifies select and control levels
  task automatic sc_3ds;
    do_reset(1'b0, DDRCA_STK_3DS, 3'h5);
    for (int c = 0; c < 8; c++)
    begin
      send(mk(1'b1, CODE_RD, '0, 2'h0, 2'h0, 3'(c)), 6);
      check("chip_id", nval, c == 5);
      check("id_ctl", {ctl.cke, ctl.odt}, (c == 5) ? 3 : 0);
    end
  endtask

  // Stack pins drive the second die's controls
  task automatic sc_ddp;
    logic [2:0] e;
    do_reset(1'b0, DDRCA_STK_DDP, 3'h0);
    for (int c = 0; c < 8; c++)
    begin
      send(mk(1'b1, CODE_RD, '0, 2'h0, 2'h0, 3'(c)), 6);
      e = {c[1], c[0], c[2]};
      check("die1", {ctl.die1_cs_n, ctl.die1_cke, ctl.die1_odt}, e);
    end
  endtask

  // Enable low freezes all state; wide dual-die ignores stack pins
  task automatic sc_ce;
    do_reset(1'b1, DDRCA_STK_DDP, 3'h0);
    send(mk(1'b1, CODE_RD, '0, 2'h0, 2'h0, 3'h7), 6);
    check("x16_die1", ctl[2:0], 3'h4);
    ce = 1'b0;
    send(mk(1'b1, CODE_WR, '0, 2'h0, 2'h0, 3'h7), 6);
    check("ce_frozen", nval, 0);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    check("ce_thaw", nval, 0);
    send(mk(1'b1, CODE_WR, '0, 2'h0, 2'h0, 3'h7), 6);
    check("ce_run", 32'(cap.kind), 32'(DDRCA_K_WR));
  endtask

  // Whole run is about six hundred cycles; this leaves ample margin
  initial
  begin
    #50000;
    miscompares++;
    print_verdict;
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    x16_strap = 1'b0;
    stack_strap = DDRCA_STK_PLAIN;
    die_id_strap = 3'h0;
    miscompares = 0;
    num_checks = 0;
    nval = 0;
    cap = CMD_RST;
    do_reset(1'b0, DDRCA_STK_PLAIN, 3'h0);
    sc_codes;
    sc_fields;
    sc_x16;
    sc_3ds;
    sc_ddp;
    sc_ce;
    print_verdict;
  end
endmodule
`default_nettype wire
